// ==== lcd_pixel_pkg.sv ====
// Function
// RQ1: active select clear means passive mode, pixels go through dither stage.
// RQ2: active 4/8-bit pixels index the palette, result sent undithered.
// RQ3: active palette output is 12 bits: four red, four green, four blue.
// RQ4: active 16-bit mode unpacks two 16-bit pixels per frame word.
// RQ5: active 16-bit pixels skip palette and dither, go straight to output.
// RQ6: panel side reads the 16 bits as 6-5-5, 5-6-5 or 5-5-6; passed unchanged.
// RQ7: active 16-bit: bits 15..8 to general pins 9..2, bits 7..0 to data pins.
// RQ8: active 4/8-bit: bits 11..8 on pins 5..2; pins 9..6 held low if claimed.
// RQ9: software sets direction and alternate function of borrowed pins beforehand.
// RQ10: little endian unpacks from least significant nibble, byte or half-word.
// RQ11: big endian unpacks from most significant nibble, byte or half-word.
// RQ12: big endian loads palette upper half-word first, else lower first.
// RQ13: endian select never reorders bits inside a palette entry.
// RQ14: single mono passive: four pixels on pins 3..0, eight with double pixel.
// RQ15: double pixel has no effect in dual mono or any colour mode.
// RQ16: active mode ignores dual panel select, runs single panel.
// RQ17: controller disabled releases all data pins to the pin controller.
// RQ18: software changes mode selections only while the controller is disabled.
package lcd_pixel_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] PAL_IDX_OFS = 4'h4;
	localparam logic [3:0] PAL_DATA_OFS = 4'h8;
	localparam logic [3:0] STATUS_OFS = 4'hC;
	// ----------------------------------------
	// control field positions and reset
	// ----------------------------------------
	localparam int EN_BIT = 0;
	localparam int MONO_BIT = 1;
	localparam int DUAL_BIT = 2;
	localparam int ACTIVE_BIT = 7;
	localparam int BIG_BIT = 8;
	localparam int DOUBLE_BIT = 9;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [7:0] PAL_IDX_RESET = 8'h00;
	// pixel size field held in palette entry zero
	localparam int PSIZE_LO = 12;
	localparam int PAL_DEPTH_DEF = 256;

	typedef enum logic [1:0] {
		PX4 = 2'h0,
		PX8 = 2'h1,
		PX16 = 2'h2
	} pix_size_t;

	typedef struct packed {
		logic dbl;
		logic big;
		logic active;
		logic dual;
		logic mono;
		logic en;
	} ctrl_t;

	typedef struct packed {
		logic [7:0] gp;
		logic [7:0] data;
	} pin_word_t;
endpackage

// ==== lcd_pixel_path.sv ====
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module lcd_pixel_path #(
	parameter int PAL_DEPTH = lcd_pixel_pkg::PAL_DEPTH_DEF
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic [31:0] fb_word_in,
	input wire logic fb_valid_in,
	output logic fb_ready_out,
	input wire logic [7:0] pin_direction_reg_in,
	input wire logic [7:0] alt_function_reg_in,
	input wire logic out_ready_in,
	output logic out_valid_out,
	output lcd_pixel_pkg::pin_word_t pins_out,
	output logic [7:0] data_oe_out,
	output logic [7:0] gp_oe_out,
	output logic controller_enable_out
);
	import lcd_pixel_pkg::*;

	ctrl_t ctrl_q;
	logic [7:0] pal_idx_q;
	logic [15:0] pal_q [PAL_DEPTH];
	logic [31:0] rdata_q;
	logic [31:0] word_q;
	logic word_valid_q;
	logic [2:0] idx_q;
	logic [15:0] out_q;
	logic out_valid_q;
	logic [31:0] acc_q;
	logic [5:0] cnt_q;
	logic [3:0] thr_q;
	pix_size_t psize;
	logic dual_eff, wide, out_can, take, last;
	logic [15:0] cur_pix, pal_val;
	logic [2:0] dith_bits;
	logic [5:0] nbits, grp, cnt_n;
	logic [31:0] acc_n;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// pick pixel i of a frame word; big endian counts from the top
	function automatic logic [15:0] extract(input logic [31:0] w, input pix_size_t s, input logic [2:0] i,
		input logic big);
		logic [2:0] k;
		logic [31:0] sh;
		k = i;
		sh = w;
		case (s)
			PX4: begin
				if (big) k = 3'd7 - i; // RQ11
				sh = w >> {k, 2'b00}; // RQ10
				extract = {12'h000, sh[3:0]};
			end
			PX8: begin
				if (big) k = 3'd3 - i; // RQ11
				sh = w >> {k, 3'b000}; // RQ10
				extract = {8'h00, sh[7:0]};
			end
			default: begin
				if (big) k = 3'd1 - i; // RQ11
				sh = w >> {k, 4'b0000}; // RQ4
				extract = sh[15:0];
			end
		endcase
	endfunction

	function automatic logic [15:0] grp_mask(input logic [5:0] g);
		if (g == 6'd4) grp_mask = 16'h000F;
		else if (g == 6'd8) grp_mask = 16'h00FF;
		else grp_mask = 16'hFFFF;
	endfunction

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	// passive has no 16-bit path, so a wide size there falls back to bytes
	always_comb begin
		dual_eff = ctrl_q.dual & ~ctrl_q.active; // RQ16
		if (pal_q[0][PSIZE_LO +: 2] == 2'b00) psize = PX4;
		else if (pal_q[0][PSIZE_LO +: 2] == 2'b01 || !ctrl_q.active) psize = PX8;
		else psize = PX16;
		wide = ctrl_q.active & (psize == PX16);
		if (ctrl_q.mono) grp = dual_eff ? 6'h08 : (ctrl_q.dbl ? 6'h08 : 6'h04); // RQ14 RQ15
		else grp = dual_eff ? 6'd16 : 6'd8; // RQ15
		nbits = ctrl_q.mono ? 6'd1 : 6'd3;
	end

	// ----------------------------------------
	// unpack and look up
	// ----------------------------------------
	always_comb begin
		cur_pix = extract(word_q, psize, idx_q, ctrl_q.big);
		pal_val = pal_q[cur_pix[7:0]];
		out_can = !out_valid_q || out_ready_in;
		take = word_valid_q && out_can && ctrl_q.en;
		if (psize == PX4) last = idx_q == 3'd7;
		else if (psize == PX8) last = idx_q == 3'd3;
		else last = idx_q == 3'd1; // RQ4
		fb_ready_out = ctrl_q.en && (!word_valid_q || (take && last));
	end

	// simple ordered threshold stands in for the real dither engine
	always_comb begin
		if (ctrl_q.mono) dith_bits = {2'b00, pal_val[3:0] > thr_q}; // RQ1
		else dith_bits = {pal_val[11:8] > thr_q, pal_val[7:4] > thr_q, pal_val[3:0] > thr_q}; // RQ1
		acc_n = acc_q | ({29'h0, dith_bits} << cnt_q);
		cnt_n = cnt_q + nbits;
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	// control writes; mode bits are expected to move only while disabled
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			ctrl_q <= CTRL_RESET;
		end else if (reg_wr_in && reg_addr_in == CTRL_OFS) begin
			ctrl_q <= {reg_wdata_in[DOUBLE_BIT], reg_wdata_in[BIG_BIT], reg_wdata_in[ACTIVE_BIT],
				reg_wdata_in[DUAL_BIT], reg_wdata_in[MONO_BIT], reg_wdata_in[EN_BIT]};
		end
	end

	// palette load: two entries a word, bits inside an entry never swapped
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			pal_idx_q <= PAL_IDX_RESET;
		end else if (reg_wr_in && reg_addr_in == PAL_IDX_OFS) begin
			pal_idx_q <= reg_wdata_in[7:0];
		end else if (reg_wr_in && reg_addr_in == PAL_DATA_OFS) begin
			pal_idx_q <= pal_idx_q + 8'd2;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reg_wr_in && reg_addr_in == PAL_DATA_OFS) begin
			pal_q[pal_idx_q] <= ctrl_q.big ? reg_wdata_in[31:16] : reg_wdata_in[15:0]; // RQ12 RQ13
			pal_q[8'(pal_idx_q + 8'd1)] <= ctrl_q.big ? reg_wdata_in[15:0] : reg_wdata_in[31:16]; // RQ12
		end
	end

	// read data stands for one cycle only; unmapped reads give zero
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in || !reg_rd_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_addr_in == CTRL_OFS) begin
			rdata_q <= {22'h0, ctrl_q.dbl, ctrl_q.big, ctrl_q.active, 4'h0, ctrl_q.dual, ctrl_q.mono, ctrl_q.en};
		end else if (reg_addr_in == PAL_IDX_OFS) begin
			rdata_q <= {24'h0, pal_idx_q};
		end else if (reg_addr_in == STATUS_OFS) begin
			rdata_q <= {16'h0, cnt_q, idx_q, psize, 2'b00, out_valid_q, word_valid_q, ctrl_q.en};
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// input word holding stage
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in || !ctrl_q.en) begin
			word_valid_q <= 1'b0;
			word_q <= 32'h0000_0000;
			idx_q <= 3'h0;
		end else if (fb_ready_out && fb_valid_in) begin
			word_valid_q <= 1'b1;
			word_q <= fb_word_in;
			idx_q <= 3'h0; // RQ10 RQ11
		end else if (take) begin
			word_valid_q <= !last;
			idx_q <= idx_q + 3'd1;
		end
	end

	// ----------------------------------------
	// output stage and passive packing
	// ----------------------------------------
	// a disabled controller drops any partial group so the next frame starts clean
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in || !ctrl_q.en) begin
			out_valid_q <= 1'b0;
			out_q <= 16'h0000;
			acc_q <= 32'h0000_0000;
			cnt_q <= 6'h00;
			thr_q <= 4'h0;
		end else begin
			if (out_valid_q && out_ready_in) out_valid_q <= 1'b0;
			if (take && ctrl_q.active) begin
				out_valid_q <= 1'b1;
				if (wide) out_q <= cur_pix; // RQ5 RQ6 RQ7
				else out_q <= {4'h0, pal_val[11:0]}; // RQ2 RQ3 RQ8
			end else if (take) begin
				thr_q <= thr_q + 4'h1;
				if (cnt_n >= grp) begin
					out_valid_q <= 1'b1;
					out_q <= acc_n[15:0] & grp_mask(grp); // RQ14
					acc_q <= acc_n >> grp;
					cnt_q <= cnt_n - grp;
				end else begin
					acc_q <= acc_n;
					cnt_q <= cnt_n;
				end
			end
		end
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	always_comb begin
		pins_out = out_q; // RQ7 RQ8
		out_valid_out = out_valid_q;
		reg_rdata_out = rdata_q;
		controller_enable_out = ctrl_q.en;
		// a disabled controller drives nothing, so the pin controller owns every pin
		data_oe_out = 8'h00; // RQ17
		gp_oe_out = 8'h00; // RQ17
		if (ctrl_q.en) begin
			data_oe_out = (!ctrl_q.active && ctrl_q.mono && !dual_eff && !ctrl_q.dbl) ? 8'h0F : 8'hFF; // RQ14
			if (wide || (dual_eff && !ctrl_q.mono)) gp_oe_out = 8'hFF; // RQ7
			else if (ctrl_q.active) begin
				// upper four only driven (low) when software handed them over
				gp_oe_out[3:0] = 4'hF; // RQ8
				if ((pin_direction_reg_in[7:4] & alt_function_reg_in[7:4]) == 4'hF) gp_oe_out[7:4] = 4'hF; // RQ8
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_palette_path: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ2
		take && ctrl_q.active && !wide |=> out_valid_q && out_q == {4'h0, $past(pal_val[11:0])})
		else $error("palette value not passed to output");
	a_direct_path: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ5
		take && wide |=> out_q == $past(cur_pix))
		else $error("16-bit pixel altered on its way out");
	a_upper_nibble_low: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ3
		out_valid_q && ctrl_q.active && !wide |-> pins_out.gp[7:4] == 4'h0)
		else $error("upper general pins not low in palette mode");
	a_half_order: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ11
		word_valid_q && wide && idx_q == 3'd0 |-> cur_pix == (ctrl_q.big ? word_q[31:16] : word_q[15:0]))
		else $error("first half-word taken from wrong end");
	a_nibble_order: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ10
		word_valid_q && psize == PX4 && idx_q == 3'd0 |-> cur_pix[3:0] == (ctrl_q.big ? word_q[31:28] : word_q[3:0]))
		else $error("first nibble taken from wrong end");
	a_two_per_word: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ4
		take && wide && idx_q == 3'd1 |=> !word_valid_q || idx_q == 3'd0)
		else $error("more than two pixels from one wide word");
	a_mono_four_pins: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ14
		out_valid_q && !ctrl_q.active && ctrl_q.mono && !dual_eff && !ctrl_q.dbl |-> out_q[15:4] == 12'h000)
		else $error("single mono group wider than four pins");
	a_dual_ignored: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ16
		ctrl_q.active |-> !dual_eff && (data_oe_out == 8'hFF || !ctrl_q.en))
		else $error("dual panel honoured in active mode");
	a_release_pins: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ17
		!ctrl_q.en |-> data_oe_out == 8'h00 && gp_oe_out == 8'h00 ##1 !out_valid_q)
		else $error("pins held while disabled");
	a_wide_pins: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ7
		ctrl_q.en && wide |-> gp_oe_out == 8'hFF && pins_out.gp == out_q[15:8])
		else $error("wide pixel upper byte not on general pins");
	// a stalled group must stand untouched until the panel takes it
	a_out_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ7
		ctrl_q.en && out_valid_q && !out_ready_in |=> out_valid_q && $stable(out_q))
		else $error("output group changed while stalled");
	// active mode must leave the dither threshold alone
	a_no_dither: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ2
		ctrl_q.en && ctrl_q.active |=> thr_q == $past(thr_q))
		else $error("dither state moved in active mode");
	// first entry of a palette word comes from the end that the endian select names
	a_palette_order: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ12
		reg_wr_in && reg_addr_in == PAL_DATA_OFS |=> pal_q[$past(pal_idx_q)] ==
		($past(ctrl_q.big) ? $past(reg_wdata_in[31:16]) : $past(reg_wdata_in[15:0])))
		else $error("first palette entry taken from wrong half");
	// second entry takes the other half, bits unchanged
	a_palette_second: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ13
		reg_wr_in && reg_addr_in == PAL_DATA_OFS |=> pal_q[8'($past(pal_idx_q) + 8'h01)] ==
		($past(ctrl_q.big) ? $past(reg_wdata_in[15:0]) : $past(reg_wdata_in[31:16])))
		else $error("second palette entry taken from wrong half");
	// double pixel widens a single mono group to the full data byte only
	a_mono_eight_pins: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ14
		out_valid_q && !ctrl_q.active && ctrl_q.mono && !dual_eff && ctrl_q.dbl |-> out_q[15:8] == 8'h00)
		else $error("double pixel group wider than eight pins");
	// pins 9..6 stay with the pin controller unless all four were handed over
	a_gp_released: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ8
		ctrl_q.en && ctrl_q.active && !wide && (pin_direction_reg_in[7:4] & alt_function_reg_in[7:4]) != 4'hF
		|-> gp_oe_out[7:4] == 4'h0 && gp_oe_out[3:0] == 4'hF)
		else $error("upper general pins driven without hand-over");
	// passive colour dual keeps its fixed pin use whatever double pixel says
	a_colour_dual_pins: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ15
		ctrl_q.en && !ctrl_q.active && ctrl_q.dual && !ctrl_q.mono |-> gp_oe_out == 8'hFF && data_oe_out == 8'hFF)
		else $error("colour dual panel pins not all driven");
	// nothing is fetched while the controller is off
	a_ready_disabled: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RQ17
		!ctrl_q.en |-> !fb_ready_out)
		else $error("frame words accepted while disabled");
endmodule

// ==== lcd_panel_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// panel side: takes one pin group per accepted handshake
// ----------------------------------------
module lcd_panel_model (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic slow_in,
	input wire logic out_valid_in,
	input wire lcd_pixel_pkg::pin_word_t pins_in,
	output logic out_ready_out
);
	import lcd_pixel_pkg::*;
	logic [15:0] got_q[$];
	// a slow panel accepts every other cycle, so the design must hold its group
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) out_ready_out <= 1'b0;
		else out_ready_out <= slow_in ? !out_ready_out : 1'b1;
	end
	// bits are kept as they arrive; the colour split is the panel's own reading
	always @(posedge clk_sys_in) begin
		if (rstn_in && out_valid_in && out_ready_out) got_q.push_back(pins_in);
	end
endmodule

// ==== lcd_pixel_path_mode_select_tb.sv ====
`timescale 1ns/1ps
module lcd_pixel_path_mode_select_tb;
	import lcd_pixel_pkg::*;
	logic clk_sys, rstn, wr, rd, fbv, slow, fb_ready, oready, ovalid, en;
	logic [3:0] addr;
	logic [31:0] wdata, fbw, rdata, v;
	logic [7:0] dir, alt, data_oe, gp_oe;
	pin_word_t pins;
	int fail_count, total_checks;
	// ----------------------------------------
	// clock, block under test and panel
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = !clk_sys;
	end
	lcd_pixel_path dut_u (.clk_sys_in(clk_sys), .rstn_in(rstn), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .fb_word_in(fbw), .fb_valid_in(fbv),
		.fb_ready_out(fb_ready), .pin_direction_reg_in(dir), .alt_function_reg_in(alt),
		.out_ready_in(oready), .out_valid_out(ovalid), .pins_out(pins), .data_oe_out(data_oe),
		.gp_oe_out(gp_oe), .controller_enable_out(en));
	lcd_panel_model panel_u (.clk_sys_in(clk_sys), .rstn_in(rstn), .slow_in(slow), .out_valid_in(ovalid),
		.pins_in(pins), .out_ready_out(oready));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd_reg(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// valid and word are held until the edge that sees ready high
	task feed(input logic [31:0] w);
		int n;
		@(posedge clk_sys);
		fbv <= 1'b1;
		fbw <= w;
		n = 0;
		#1;
		while (fb_ready !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			#1 n++;
		end
		@(posedge clk_sys);
		fbv <= 1'b0;
	endtask
	task pop_px(output logic [31:0] g);
		int n;
		n = 0;
		while (panel_u.got_q.size() == 0 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		if (panel_u.got_q.size() > 0) g = {16'h0000, panel_u.got_q.pop_front()};
		else g = 'x;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		rd_reg(CTRL_OFS, 32'h0000_0000);
		wr_reg(CTRL_OFS, 32'hFFFF_FFFF);
		rd_reg(CTRL_OFS, 32'h0000_0387);
		chk(en, 1'b1);
		rd_reg(4'h1, 32'h0000_0000);
		rd_reg(PAL_DATA_OFS, 32'h0000_0000);
		wr_reg(CTRL_OFS, 32'h0000_0000);
		#1 chk({en, fb_ready, ovalid, data_oe, gp_oe}, 32'h0);
		$display("test regs done");
	endtask
	task t_active16;
		dir <= 8'hFF;
		alt <= 8'hFF;
		wr_reg(PAL_IDX_OFS, 32'h0000_0000);
		wr_reg(PAL_DATA_OFS, 32'h0000_2000);
		wr_reg(CTRL_OFS, 32'h0000_0081);
		#1 chk(gp_oe, 8'hFF);
		feed(32'h5A3C_C3A5);
		pop_px(v);
		chk(v, 32'h0000_C3A5);
		pop_px(v);
		chk(v, 32'h0000_5A3C);
		wr_reg(CTRL_OFS, 32'h0000_0000);
		wr_reg(CTRL_OFS, 32'h0000_0181);
		slow <= 1'b1;
		feed(32'h1234_5678);
		pop_px(v);
		chk(v, 32'h0000_1234);
		pop_px(v);
		chk(v, 32'h0000_5678);
		slow <= 1'b0;
		wr_reg(CTRL_OFS, 32'h0000_0000);
		$display("test active16 done");
	endtask
	// four-bit pixels: palette entry zero selects the size, both endian orders
	task t_active4;
		logic [31:0] e;
		wr_reg(PAL_IDX_OFS, 32'h0000_0000);
		wr_reg(PAL_DATA_OFS, 32'h0654_0321);
		for (int b = 0; b < 2; b++) begin
			wr_reg(CTRL_OFS, 32'h0000_0000);
			wr_reg(CTRL_OFS, b ? 32'h0000_0181 : 32'h0000_0081);
			#1 chk(gp_oe, 8'hFF);
			feed(32'h0000_0001);
			for (int i = 0; i < 8; i++) begin
				e = (i == (b ? 7 : 0)) ? 32'h0000_0654 : 32'h0000_0321;
				pop_px(v);
				chk(v, e);
			end
		end
		wr_reg(CTRL_OFS, 32'h0000_0000);
		$display("test active4 done");
	endtask
	task t_palette;
		wr_reg(CTRL_OFS, 32'h0000_0100);
		wr_reg(PAL_IDX_OFS, 32'h0000_0000);
		wr_reg(PAL_DATA_OFS, 32'h1ABC_0123);
		wr_reg(CTRL_OFS, 32'h0000_0181);
		alt <= 8'h0F;
		#1 chk(gp_oe[7:4], 4'h0);
		feed(32'h0001_0100);
		pop_px(v);
		chk(v, 32'h0000_0ABC);
		pop_px(v);
		chk(v, 32'h0000_0123);
		pop_px(v);
		chk(v, 32'h0000_0123);
		pop_px(v);
		chk(v, 32'h0000_0ABC);
		alt <= 8'hFF;
		#1 chk(gp_oe[7:4], 4'hF);
		wr_reg(CTRL_OFS, 32'h0000_0000);
		$display("test palette done");
	endtask
	task t_pins;
		logic [31:0] cfg [7] = '{32'h003, 32'h203, 32'h007, 32'h207, 32'h201, 32'h085, 32'h005};
		logic [7:0] oe [7] = '{8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		logic [7:0] gpe [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
		for (int i = 0; i < 7; i++) begin
			wr_reg(CTRL_OFS, 32'h0000_0000);
			wr_reg(CTRL_OFS, cfg[i]);
			#1 chk({gp_oe, data_oe}, {gpe[i], oe[i]});
		end
		// passive mono single: the group fills data pins 3..0 only
		wr_reg(CTRL_OFS, 32'h0000_0000);
		panel_u.got_q.delete();
		wr_reg(CTRL_OFS, 32'h0000_0003);
		feed(32'h0000_0000);
		pop_px(v);
		chk(v & 32'hFFFF_FFF0, 32'h0);
		// double pixel: eight one-bit pixels fill data pins 7..0
		wr_reg(CTRL_OFS, 32'h0000_0000);
		wr_reg(CTRL_OFS, 32'h0000_0203);
		feed(32'h0000_0000);
		feed(32'h0000_0000);
		pop_px(v);
		chk(v & 32'hFFFF_FF00, 32'h0);
		wr_reg(CTRL_OFS, 32'h0000_0000);
		$display("test pins done");
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		{rstn, wr, rd, fbv, slow, addr, wdata, fbw, dir, alt} = '0;
		fail_count = 0;
		total_checks = 0;
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		t_regs();
		t_active16();
		t_active4();
		t_palette();
		t_pins();
		conclude();
	end
	// the whole run needs a few hundred cycles; this limit is far beyond that
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
endmodule
